// [rtl/csr_pkg.sv]
// constants shared by the clocked serial master receiver
package csr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [15:0] ADDR_PORT_CTL = 16'hff91;
  localparam logic [15:0] ADDR_FORMAT = 16'hffa8;
  localparam logic [15:0] ADDR_RATE_DIV = 16'hffa9;
  localparam logic [15:0] ADDR_CTL = 16'hffaa;
  localparam logic [15:0] ADDR_STATUS = 16'hffac;
  localparam logic [15:0] ADDR_RX_HOLD = 16'hffad;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PORT_RX_INVERT = 2;
  localparam int FMT_COMM_MODE = 7;
  localparam int FMT_MULTIPROC = 2;
  localparam int FMT_BRG_SRC_HI = 1;
  localparam int FMT_BRG_SRC_LO = 0;
  localparam int CTL_RX_ON = 4;
  localparam int CTL_CLK_SRC_HI = 1;
  localparam int CTL_CLK_SRC_LO = 0;
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAME_FAULT = 4;
  localparam int ST_PARITY_FAULT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_PORT_CTL = 8'h00;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_RATE_DIV = 8'hff;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_RX_HOLD = 8'h00;
  localparam logic RST_TX_EMPTY = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // frame and timing
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] FRAME_BITS_C = 4'h8;
  localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
  // cycles of the 125 MHz clock per half serial bit per divisor step
  localparam int CLK_MHZ = 125;
  localparam int HALF_BIT_NS_PER_STEP = 400;
  localparam int BRG_BASE = (HALF_BIT_NS_PER_STEP * CLK_MHZ) / 1000;
  localparam int BRG_CNT_W = 24;

  typedef enum logic [1:0] {
    CSR_IDLE = 2'b00,
    CSR_CLK_LO = 2'b01,
    CSR_CLK_HI = 2'b11,
    CSR_DONE = 2'b10
  } csr_state_t;

endpackage : csr_pkg

// [rtl/csr_rate_gen.sv]
// bit rate generator: half-bit tick from prescaler and divisor
`timescale 1ns/1ps
module csr_rate_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_run,
  input wire logic [1:0] i_src,
  input wire logic [7:0] i_divisor,
  // tick
  output logic o_tick
);

  logic [csr_pkg::BRG_CNT_W-1:0] cnt_q;
  logic [csr_pkg::BRG_CNT_W-1:0] limit;
  logic [csr_pkg::BRG_CNT_W-1:0] steps;
  logic [csr_pkg::BRG_CNT_W-1:0] base;

  assign base = csr_pkg::BRG_CNT_W'(csr_pkg::BRG_BASE);
  // source 0 is the undivided clock; others scale by 4, 16, 64
  assign steps = csr_pkg::BRG_CNT_W'({8'h00, 8'h00, i_divisor} + 24'h000001) << {i_src, 1'b0}; // RULE9
  assign limit = csr_pkg::BRG_CNT_W'(steps * base) - 24'h000001; // RULE10
  // compare is >= so a divisor lowered mid-count cannot run the counter past its limit
  assign o_tick = i_run && (cnt_q >= limit);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (!i_run || o_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

endmodule : csr_rate_gen

// [rtl/csr_rx.sv]
// clocked serial master receiver with cpu register port
// Operation
// RULE1: frames carry exactly eight data bits
// RULE2: first received bit lands in bit 0
// RULE3: full frame copies into holding register automatically
// RULE4: shifter and holding register double buffer
// RULE5: holding register ignores cpu writes
// RULE6: status flags clear on zero, one keeps
// RULE7: format bit 7 set selects synchronous mode
// RULE8: format bit 2 clear disables multiprocessor function
// RULE9: clock select zero feeds undivided clock
// RULE10: divisor register sets the bit rate
// RULE11: control bit 4 enables reception on pin
// RULE12: clock enable zero drives clock out, master
// RULE13: status bit 6 shows byte held
// RULE14: status bit 5 flags overrun
// RULE15: status bit 4 flags framing error
// RULE16: status bit 3 flags parity error
// RULE17: port bit 2 clear passes data uninverted
// RULE18: overrun keeps unread byte, sets flag
// RULE19: remote presents one bit per clock
`timescale 1ns/1ps
module csr_rx (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // cpu register port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // serial pins
  input wire logic i_rx_pin,
  output logic o_sync_clk_pin,
  output logic o_sync_clk_pin_oe,
  output logic o_tx_pin,
  output logic o_tx_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0] port_ctl_q;
  logic [7:0] format_q;
  logic [7:0] rate_div_q;
  logic [7:0] ctl_q;
  logic [7:0] rx_hold_q;
  logic [7:0] rx_shift_q;
  logic [3:0] bit_cnt_q;
  logic tx_empty_q;
  logic rx_full_q;
  logic overrun_q;
  logic frame_fault_q;
  logic parity_fault_q;
  logic [7:0] rdata_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic sclk_q;
  csr_pkg::csr_state_t state_q;
  csr_pkg::csr_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic wr_port;
  logic wr_fmt;
  logic wr_div;
  logic wr_ctl;
  logic wr_st;
  logic sync_mode;
  logic multiproc;
  logic master;
  logic rx_on;
  logic rx_invert;
  logic rx_bit;
  logic run;
  logic tick;
  logic frame_end;
  logic load_hold;
  logic set_overrun;
  logic sample;
  logic clr_tx_empty;
  logic clr_rx_full;
  logic clr_overrun;
  logic clr_frame_fault;
  logic clr_parity_fault;
  logic [7:0] status_rd;
  logic [7:0] rd_mux;

  assign wr_port = i_wr && (i_addr == csr_pkg::ADDR_PORT_CTL);
  assign wr_fmt = i_wr && (i_addr == csr_pkg::ADDR_FORMAT);
  assign wr_div = i_wr && (i_addr == csr_pkg::ADDR_RATE_DIV);
  assign wr_ctl = i_wr && (i_addr == csr_pkg::ADDR_CTL);
  assign wr_st = i_wr && (i_addr == csr_pkg::ADDR_STATUS);

  // a status write clears each flag whose bit is written zero
  assign clr_tx_empty = wr_st && !i_wdata[csr_pkg::ST_TX_EMPTY]; // RULE6
  assign clr_rx_full = wr_st && !i_wdata[csr_pkg::ST_RX_FULL]; // RULE6
  assign clr_overrun = wr_st && !i_wdata[csr_pkg::ST_OVERRUN]; // RULE6
  assign clr_frame_fault = wr_st && !i_wdata[csr_pkg::ST_FRAME_FAULT]; // RULE6
  assign clr_parity_fault = wr_st && !i_wdata[csr_pkg::ST_PARITY_FAULT]; // RULE6

  assign sync_mode = format_q[csr_pkg::FMT_COMM_MODE]; // RULE7
  // multiprocessor framing has no meaning in synchronous mode; bit only stored
  assign multiproc = format_q[csr_pkg::FMT_MULTIPROC] && !sync_mode; // RULE8
  assign master = ({ctl_q[csr_pkg::CTL_CLK_SRC_HI], ctl_q[csr_pkg::CTL_CLK_SRC_LO]}
                   == csr_pkg::CLK_SRC_INTERNAL); // RULE12
  assign rx_on = ctl_q[csr_pkg::CTL_RX_ON]; // RULE11
  assign rx_invert = port_ctl_q[csr_pkg::PORT_RX_INVERT];
  assign rx_bit = rx_sync_q ^ rx_invert; // RULE17

  // clock stops while overrun is pending, so no byte is lost silently
  assign run = sync_mode && master && rx_on && !overrun_q && !multiproc;
  assign sample = (state_q == csr_pkg::CSR_CLK_LO) && tick;
  assign frame_end = (state_q == csr_pkg::CSR_DONE);
  assign load_hold = frame_end && !rx_full_q; // RULE3
  assign set_overrun = frame_end && rx_full_q; // RULE18

  ////////////////////////////////////////////////////////////////////////////
  // bit rate generator
  csr_rate_gen u_rate (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_run(run && (state_q != csr_pkg::CSR_IDLE)),
    .i_src({format_q[csr_pkg::FMT_BRG_SRC_HI], format_q[csr_pkg::FMT_BRG_SRC_LO]}),
    .i_divisor(rate_div_q),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= i_rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      csr_pkg::CSR_IDLE: begin
        if (run) begin
          state_d = csr_pkg::CSR_CLK_LO;
        end
      end
      csr_pkg::CSR_CLK_LO: begin
        if (!run) begin
          state_d = csr_pkg::CSR_IDLE;
        end else if (tick) begin
          state_d = csr_pkg::CSR_CLK_HI;
        end
      end
      csr_pkg::CSR_CLK_HI: begin
        // rate counter is held at zero once run drops, so a cut frame must leave here
        if (!run) begin
          state_d = csr_pkg::CSR_IDLE;
        end else if (tick) begin
          if (bit_cnt_q == csr_pkg::FRAME_BITS_C) begin // RULE1
            state_d = csr_pkg::CSR_DONE;
          end else begin
            state_d = csr_pkg::CSR_CLK_LO;
          end
        end
      end
      csr_pkg::CSR_DONE: begin
        state_d = csr_pkg::CSR_IDLE;
      end
      default: begin
        state_d = csr_pkg::CSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= csr_pkg::CSR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // data changes on the falling edge, sampled on the rising edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= (state_d != csr_pkg::CSR_CLK_LO);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_q <= 4'h0;
    end else if (state_q == csr_pkg::CSR_IDLE || frame_end) begin
      bit_cnt_q <= 4'h0;
    end else if (sample) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_shift_q <= 8'h00;
    end else if (sample) begin
      rx_shift_q <= {rx_bit, rx_shift_q[7:1]}; // RULE2 RULE19
    end
  end

  // shifter refills while the held byte waits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_hold_q <= csr_pkg::RST_RX_HOLD;
    end else if (load_hold) begin
      rx_hold_q <= rx_shift_q; // RULE4 RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  // inversion applies from the next sampled bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_ctl_q <= csr_pkg::RST_PORT_CTL;
    end else if (wr_port) begin
      port_ctl_q <= i_wdata; // RULE17
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      format_q <= csr_pkg::RST_FORMAT;
    end else if (wr_fmt) begin
      format_q <= i_wdata; // RULE7
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_div_q <= csr_pkg::RST_RATE_DIV;
    end else if (wr_div) begin
      rate_div_q <= i_wdata; // RULE10
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl_q <= csr_pkg::RST_CTL;
    end else if (wr_ctl) begin
      ctl_q <= i_wdata; // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: writing zero clears, a same-cycle set wins
  // transmit path absent: this flag is only ever cleared
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_empty_q <= csr_pkg::RST_TX_EMPTY;
    end else if (clr_tx_empty) begin
      tx_empty_q <= 1'b0; // RULE6
    end
  end

  // reading the holding register does not clear this flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_full_q <= 1'b0;
    end else if (load_hold) begin
      rx_full_q <= 1'b1; // RULE13
    end else if (clr_rx_full) begin
      rx_full_q <= 1'b0; // RULE6
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overrun_q <= 1'b0;
    end else if (set_overrun) begin
      overrun_q <= 1'b1; // RULE14
    end else if (clr_overrun) begin
      overrun_q <= 1'b0; // RULE6
    end
  end

  // no stop or parity bit in synchronous frames, so these never set here
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_fault_q <= 1'b0;
    end else if (clr_frame_fault) begin
      frame_fault_q <= 1'b0; // RULE15
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      parity_fault_q <= 1'b0;
    end else if (clr_parity_fault) begin
      parity_fault_q <= 1'b0; // RULE16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    status_rd = 8'h00;
    status_rd[csr_pkg::ST_TX_EMPTY] = tx_empty_q;
    status_rd[csr_pkg::ST_RX_FULL] = rx_full_q; // RULE13
    status_rd[csr_pkg::ST_OVERRUN] = overrun_q;
    status_rd[csr_pkg::ST_FRAME_FAULT] = frame_fault_q;
    status_rd[csr_pkg::ST_PARITY_FAULT] = parity_fault_q;
  end

  assign rd_mux = (i_addr == csr_pkg::ADDR_PORT_CTL) ? port_ctl_q :
                  (i_addr == csr_pkg::ADDR_FORMAT) ? format_q :
                  (i_addr == csr_pkg::ADDR_RATE_DIV) ? rate_div_q :
                  (i_addr == csr_pkg::ADDR_CTL) ? ctl_q :
                  (i_addr == csr_pkg::ADDR_STATUS) ? status_rd :
                  (i_addr == csr_pkg::ADDR_RX_HOLD) ? rx_hold_q : 8'h00;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_rdata = rdata_q;
  assign o_sync_clk_pin = sclk_q;
  assign o_sync_clk_pin_oe = sync_mode && master; // RULE12
  // transmit path absent: line parked high, undriven
  assign o_tx_pin = 1'b1;
  assign o_tx_pin_oe = 1'b0;

endmodule : csr_rx

// [tb/csr_rx_checker.sv]
// port assertions for the serial receiver
`timescale 1ns/1ps
module csr_rx_checker (
  // bus
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  // pins
  input wire logic i_rx_pin,
  input wire logic o_sync_clk_pin,
  input wire logic o_sync_clk_pin_oe,
  input wire logic o_tx_pin,
  input wire logic o_tx_pin_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // shortest half bit is 50 cycles, so 8 is a safe floor
  sequence low_run;
    !o_sync_clk_pin [*8];
  endsequence
  sequence high_run;
    o_sync_clk_pin [*8];
  endsequence
  clk_low_a: assert property ($fell(o_sync_clk_pin) |-> low_run) else $error("short low half");
  clk_high_a: assert property ($rose(o_sync_clk_pin) |-> high_run) else $error("short high half");
  clk_idle_a: assert property (!o_sync_clk_pin_oe |-> o_sync_clk_pin) else $error("clock runs undriven");
  clk_master_a: assert property ($fell(o_sync_clk_pin) |-> o_sync_clk_pin_oe) else $error("clock not driven");
  ext_clk_a: assert property (i_wr && i_addr == csr_pkg::ADDR_CTL && i_wdata[1:0] != 2'h0
    |=> !o_sync_clk_pin_oe) else $error("drives clock on external source");
  async_mode_a: assert property (i_wr && i_addr == csr_pkg::ADDR_FORMAT && !i_wdata[7]
    |=> !o_sync_clk_pin_oe) else $error("drives clock in async mode");
  fault_bits_a: assert property (i_rd && i_addr == csr_pkg::ADDR_STATUS |=> o_rdata[4:0] == 5'h00)
    else $error("fault or low status bits set");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("read data moved");
  tx_quiet_a: assert property (o_tx_pin && !o_tx_pin_oe) else $error("tx pin active");
endmodule : csr_rx_checker

bind csr_rx csr_rx_checker i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rx_pin(i_rx_pin), .o_sync_clk_pin(o_sync_clk_pin),
  .o_sync_clk_pin_oe(o_sync_clk_pin_oe), .o_tx_pin(o_tx_pin), .o_tx_pin_oe(o_tx_pin_oe));

// [tb/csr_remote_tx.sv]
// remote clocked transmitter model
`timescale 1ns/1ps
module csr_remote_tx (
  // link
  input wire logic i_sclk,
  input wire logic [7:0] i_byte,
  output logic o_rx
);
  logic [7:0] sh_q;
  logic [2:0] n_q;
  initial begin
    o_rx = 1'b1;
    n_q = 3'h0;
    sh_q = 8'h00;
  end
  // new bit on each falling edge, byte latched at frame start
  always @(negedge i_sclk) begin
    if (n_q == 3'h0) begin
      sh_q = i_byte;
    end
    o_rx <= sh_q[n_q];
    n_q <= n_q + 3'h1;
  end
  // after the last bit the line stops showing data
  always @(posedge i_sclk) begin
    if (n_q == 3'h0) begin
      o_rx <= ~o_rx;
    end
  end
endmodule : csr_remote_tx

// [tb/tb_csr_rx.sv]
// self-checking bench for the serial receiver
`timescale 1ns/1ps
module tb_csr_rx;
  logic i_clk, i_rst_n, i_wr, i_rd, rx, sclk, sclk_oe;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, tx_byte, v;
  int n_mismatch, comparisons, cyc, n;
  csr_rx i_csr_rx (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rx_pin(rx), .o_sync_clk_pin(sclk), .o_sync_clk_pin_oe(sclk_oe),
    .o_tx_pin(), .o_tx_pin_oe());
  csr_remote_tx i_csr_remote_tx (.i_sclk(sclk), .i_byte(tx_byte), .o_rx(rx));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // whole run needs about 7000 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
    chk(what, exp, v);
  endtask : rc
  // polls status; the value seen is left in v
  task automatic wait_flag(input int b);
    v = 8'h00;
    for (int k = 0; k < 3000 && v[b] !== 1'b1; k++) begin
      @(posedge i_clk);
      i_addr <= csr_pkg::ADDR_STATUS;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
    end
  endtask : wait_flag
  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_scn();
    rc(csr_pkg::ADDR_PORT_CTL, csr_pkg::RST_PORT_CTL, "port_control");
    rc(csr_pkg::ADDR_FORMAT, csr_pkg::RST_FORMAT, "serial_format");
    rc(csr_pkg::ADDR_RATE_DIV, csr_pkg::RST_RATE_DIV, "bit_rate_divisor");
    rc(csr_pkg::ADDR_CTL, csr_pkg::RST_CTL, "serial_control");
    rc(csr_pkg::ADDR_STATUS, {csr_pkg::RST_TX_EMPTY, 7'h00}, "serial_status");
    wr(csr_pkg::ADDR_RX_HOLD, 8'h5a);
    rc(csr_pkg::ADDR_RX_HOLD, csr_pkg::RST_RX_HOLD, "receive_holding");
    rc(16'hff00, 8'h00, "unmapped");
  endtask : reg_scn
  task automatic rx_scn();
    wr(csr_pkg::ADDR_PORT_CTL, 8'h00);
    wr(csr_pkg::ADDR_RATE_DIV, 8'h00);
    wr(csr_pkg::ADDR_FORMAT, 8'h80);
    wr(csr_pkg::ADDR_CTL, 8'h10);
    chk("clock enable", 8'h01, {7'h00, sclk_oe});
    @(negedge sclk);
    @(posedge i_clk);
    tx_byte <= 8'h3c;
    wait_flag(csr_pkg::ST_RX_FULL);
    chk("status", 8'hc0, v);
    rc(csr_pkg::ADDR_RX_HOLD, 8'ha5, "receive_holding");
    wr(csr_pkg::ADDR_STATUS, 8'hbf);
    @(negedge sclk);
    @(posedge i_clk);
    tx_byte <= 8'h0f;
    wait_flag(csr_pkg::ST_RX_FULL);
    rc(csr_pkg::ADDR_RX_HOLD, 8'h3c, "receive_holding");
    wait_flag(csr_pkg::ST_OVERRUN);
    chk("status", 8'he0, v);
    rc(csr_pkg::ADDR_RX_HOLD, 8'h3c, "receive_holding");
    n = 0;
    repeat (300) begin
      @(posedge i_clk);
      n += (sclk !== 1'b1);
    end
    chk("clock stopped", 8'h00, n[7:0]);
    wr(csr_pkg::ADDR_CTL, 8'h11);
    #1;
    chk("clock enable", 8'h00, {7'h00, sclk_oe});
    wr(csr_pkg::ADDR_CTL, 8'h10);
    wr(csr_pkg::ADDR_FORMAT, 8'h00);
    #1;
    chk("clock enable", 8'h00, {7'h00, sclk_oe});
    wr(csr_pkg::ADDR_FORMAT, 8'h80);
    #1;
    chk("clock enable", 8'h01, {7'h00, sclk_oe});
    wr(csr_pkg::ADDR_STATUS, 8'hff);
    rc(csr_pkg::ADDR_STATUS, 8'he0, "serial_status");
    wr(csr_pkg::ADDR_PORT_CTL, 8'h04);
    wr(csr_pkg::ADDR_RATE_DIV, 8'h04);
    wr(csr_pkg::ADDR_STATUS, 8'h9f);
    rc(csr_pkg::ADDR_STATUS, 8'h80, "serial_status");
    @(negedge sclk);
    @(negedge sclk);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (sclk === 1'b0);
    chk("half bit", 8'((8'h04 + 1) * csr_pkg::BRG_BASE), n[7:0]);
    wait_flag(csr_pkg::ST_RX_FULL);
    chk("status", 8'hc0, v);
    rc(csr_pkg::ADDR_RX_HOLD, 8'hf0, "receive_holding");
  endtask : rx_scn
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    tx_byte = 8'ha5;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    reg_scn();
    rx_scn();
    close_out();
  end
endmodule : tb_csr_rx
